// ---- rtl/rps_pkg.sv ----
// Constants for the receive-port remote status register group
package rps_pkg;
   // Register offsets on the local register port
   localparam logic [7:0] ADDR_VOLT_LEVELS = 8'h52;
   localparam logic [7:0] ADDR_TEMP_LEVEL = 8'h53;
   localparam logic [7:0] ADDR_CSI_FLAGS = 8'h54;
   localparam logic [7:0] ADDR_PAR_HIGH = 8'h55;
   localparam logic [7:0] ADDR_PAR_LOW = 8'h56;
   localparam logic [7:0] ADDR_BIST_COUNT = 8'h57;
   // Field positions
   localparam int VOLT_B_LSB = 4;
   localparam int VOLT_A_LSB = 0;
   localparam int TEMP_LSB = 0;
   localparam int CSI_FLAG_LSB = 0;
   localparam int PAR_UPPER_LSB = 8;
   // Field widths
   localparam int LEVEL_W = 3;
   localparam int CSI_FLAG_W = 5;
   localparam int PAR_CNT_W = 16;
   localparam int BIST_CNT_W = 8;
   // Values after reset
   localparam logic [2:0] LEVEL_RST = 3'h0;
   localparam logic [4:0] CSI_FLAG_RST = 5'h00;
   localparam logic [15:0] PAR_CNT_RST = 16'h0000;
   localparam logic [7:0] BIST_CNT_RST = 8'h00;
   localparam logic [7:0] RD_DATA_RST = 8'h00;
   // Register selector, one-hot
   typedef enum logic [6:0] {
      RPS_SEL_NONE = 7'h01,
      RPS_SEL_VOLT = 7'h02,
      RPS_SEL_TEMP = 7'h04,
      RPS_SEL_CSI = 7'h08,
      RPS_SEL_PARH = 7'h10,
      RPS_SEL_PARL = 7'h20,
      RPS_SEL_BIST = 7'h40
   } rps_sel_t;
endpackage

// ---- rtl/rps_parity_counter.sv ----
// Link parity error counter of one receive port
`timescale 1ns/1ps
module rps_parity_counter #(
   parameter int CNT_W = rps_pkg::PAR_CNT_W
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic lockDetect,
   input wire logic parityErr,
   input wire logic readClear,
   output logic [CNT_W-1:0] count
);
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] count_nxt;
   logic [CNT_W-1:0] base;
   logic lockPrev_r;
   logic lockRise;

   // Edge of newly detected lock
   assign lockRise = lockDetect & ~lockPrev_r;

   // Restart on lock or low-byte read; a new error still counts
   always_comb
   begin
      base = (lockRise | readClear) ? CNT_W'(0) : count_r;
      count_nxt = base;
      if (parityErr && (base != {CNT_W{1'b1}})) // Saturates at all ones
      begin
         count_nxt = base + CNT_W'(1);
      end
   end

   // Lock history
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         lockPrev_r <= 1'b0;
      else
         lockPrev_r <= lockDetect;
   end

   // Counter state
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         count_r <= rps_pkg::PAR_CNT_RST;
      else
         count_r <= count_nxt;
   end

   assign count = count_r;
endmodule

// ---- rtl/rps_port_status.sv ----
// Mirrored remote sensor status and self-test count of one port
`timescale 1ns/1ps
module rps_port_status
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic fcStatusValid,
   input wire logic [2:0] fcVoltLevelA,
   input wire logic [2:0] fcVoltLevelB,
   input wire logic [2:0] fcTempLevel,
   input wire logic [4:0] fcCsiFlags,
   input wire logic bistStart,
   input wire logic bistErr,
   output logic [2:0] remoteVoltageLevelA,
   output logic [2:0] remoteVoltageLevelB,
   output logic [2:0] remoteTempLevel,
   output logic [4:0] remoteCsiFlags,
   output logic [7:0] bistCount
);
   logic [2:0] voltA_r;
   logic [2:0] voltB_r;
   logic [2:0] temp_r;
   logic [4:0] csi_r;
   logic [7:0] bist_r;
   logic [7:0] bistBase;

   // Load from the forward channel only, never from software
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         voltA_r <= rps_pkg::LEVEL_RST;
         voltB_r <= rps_pkg::LEVEL_RST;
         temp_r <= rps_pkg::LEVEL_RST;
         csi_r <= rps_pkg::CSI_FLAG_RST;
      end
      else if (fcStatusValid)
      begin
         voltA_r <= fcVoltLevelA;
         voltB_r <= fcVoltLevelB;
         temp_r <= fcTempLevel;
         csi_r <= fcCsiFlags;
      end
   end

   // Self-test error count, restarted by a new test, saturating
   assign bistBase = bistStart ? 8'h00 : bist_r;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         bist_r <= rps_pkg::BIST_CNT_RST;
      else if (bistErr && (bistBase != 8'hFF))
         bist_r <= bistBase + 8'h01;
      else
         bist_r <= bistBase;
   end

   assign remoteVoltageLevelA = voltA_r;
   assign remoteVoltageLevelB = voltB_r;
   assign remoteTempLevel = temp_r;
   assign remoteCsiFlags = csi_r;
   assign bistCount = bist_r;
endmodule

// ---- rtl/rps_remote_status_regs.sv ----
// Per-port remote status register group behind the local register port
// Functional notes
// - Each register exists per port; accesses reach the port-select copy.
// - Sensor status loads from forward channel only, never by software.
// - Second sensor register bits 6:4 hold remote voltage level B.
// - Second sensor register bits 2:0 hold remote voltage level A.
// - Third sensor register bits 2:0 hold temperature level; 7:3 reserved.
// - Fourth sensor register bits 4:0 hold the five remote CSI-2 flags.
// - Count link parity errors in 16 bits, high and low bytes apart.
// - Parity counter restarts on new lock and on low-byte read.
// - Reading low byte also clears high byte; read high byte first.
// - Low byte register clears as a side effect of its read.
// - Read-only byte reports selected port's self-test error count.
`timescale 1ns/1ps
module rps_remote_status_regs #(
   parameter int NUM_PORTS = 4,
   parameter int SEL_W = 2
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [SEL_W-1:0] portSelect,
   input wire logic [7:0] regAddr,
   input wire logic regRdEn,
   input wire logic regWrEn,
   input wire logic [NUM_PORTS-1:0] fcStatusValid,
   input wire logic [NUM_PORTS*3-1:0] fcVoltLevelA,
   input wire logic [NUM_PORTS*3-1:0] fcVoltLevelB,
   input wire logic [NUM_PORTS*3-1:0] fcTempLevel,
   input wire logic [NUM_PORTS*5-1:0] fcCsiFlags,
   input wire logic [NUM_PORTS-1:0] lockDetect,
   input wire logic [NUM_PORTS-1:0] parityErr,
   input wire logic [NUM_PORTS-1:0] bistStart,
   input wire logic [NUM_PORTS-1:0] bistErr,
   output logic [7:0] regRdData,
   output logic regRdValid,
   output logic regHit
);
   // Per-port views
   logic [2:0] voltA [NUM_PORTS];
   logic [2:0] voltB [NUM_PORTS];
   logic [2:0] tempLvl [NUM_PORTS];
   logic [4:0] csiFlags [NUM_PORTS];
   logic [7:0] bistCnt [NUM_PORTS];
   logic [15:0] parCnt [NUM_PORTS];
   logic [NUM_PORTS-1:0] parReadClear;
   // Per-port register images, reserved bits already zero
   logic [7:0] imgVolt [NUM_PORTS];
   logic [7:0] imgTemp [NUM_PORTS];
   logic [7:0] imgCsi [NUM_PORTS];
   logic [7:0] imgParHigh [NUM_PORTS];
   logic [7:0] imgParLow [NUM_PORTS];
   logic [7:0] imgBist [NUM_PORTS];
   logic [NUM_PORTS-1:0] portHot;

   rps_pkg::rps_sel_t regSel;
   logic portValid;
   logic [7:0] rdMux;
   logic [7:0] regRdData_r;
   logic [7:0] regRdData_nxt;
   logic regRdValid_r;
   logic regHit_r;
   logic regHit_nxt;
   // Access qualifiers and selected-port images
   logic rdAccess;
   logic wrAccess;
   logic lowRead;
   logic [7:0] selVolt;
   logic [7:0] selTemp;
   logic [7:0] selCsi;
   logic [7:0] selParHigh;
   logic [7:0] selParLow;
   logic [7:0] selBist;

   // Offset decode into a one-hot selector
   function automatic rps_pkg::rps_sel_t decodeAddr(input logic [7:0] addr);
      case (addr)
         rps_pkg::ADDR_VOLT_LEVELS: decodeAddr = rps_pkg::RPS_SEL_VOLT;
         rps_pkg::ADDR_TEMP_LEVEL: decodeAddr = rps_pkg::RPS_SEL_TEMP;
         rps_pkg::ADDR_CSI_FLAGS: decodeAddr = rps_pkg::RPS_SEL_CSI;
         rps_pkg::ADDR_PAR_HIGH: decodeAddr = rps_pkg::RPS_SEL_PARH;
         rps_pkg::ADDR_PAR_LOW: decodeAddr = rps_pkg::RPS_SEL_PARL;
         rps_pkg::ADDR_BIST_COUNT: decodeAddr = rps_pkg::RPS_SEL_BIST;
         default: decodeAddr = rps_pkg::RPS_SEL_NONE;
      endcase
   endfunction

   // Place a narrow field in a byte, other bits zero
   function automatic logic [7:0] placeField(input logic [7:0] field,
                                             input int lsb);
      placeField = 8'(field << lsb);
   endfunction

   // Voltage byte: level B in 6:4, level A in 2:0
   function automatic logic [7:0] packVolt(input logic [2:0] lvlB,
                                           input logic [2:0] lvlA);
      packVolt = placeField({5'h00, lvlB}, rps_pkg::VOLT_B_LSB)
               | placeField({5'h00, lvlA}, rps_pkg::VOLT_A_LSB);
   endfunction

   // Temperature byte: level in 2:0, upper bits reserved
   function automatic logic [7:0] packTemp(input logic [2:0] lvl);
      packTemp = placeField({5'h00, lvl}, rps_pkg::TEMP_LSB);
   endfunction

   // Flag byte: five remote CSI-2 flags, upper bits reserved
   function automatic logic [7:0] packCsi(input logic [4:0] flags);
      packCsi = placeField({3'h0, flags}, rps_pkg::CSI_FLAG_LSB);
   endfunction

   // True for any offset of this group
   function automatic logic isMapped(input rps_pkg::rps_sel_t sel);
      isMapped = (sel != rps_pkg::RPS_SEL_NONE);
   endfunction

   // One-hot port decode; an out-of-range select picks no port
   function automatic logic [NUM_PORTS-1:0] portDecode(
      input logic [SEL_W-1:0] sel);
      portDecode = '0;
      for (int i = 0; i < NUM_PORTS; i++)
      begin
         if (32'(sel) == i)
         begin
            portDecode[i] = 1'b1;
         end
      end
   endfunction

   assign regSel = decodeAddr(regAddr);
   assign portValid = (32'(portSelect) < NUM_PORTS);
   assign portHot = portDecode(portSelect);

   // Access qualifiers; a write only ever raises the hit flag
   assign rdAccess = regRdEn && isMapped(regSel) && portValid;
   assign wrAccess = regWrEn && isMapped(regSel) && portValid;
   assign lowRead = rdAccess && (regSel == rps_pkg::RPS_SEL_PARL);

   // One status copy and one parity counter per port
   for (genvar p = 0; p < NUM_PORTS; p++)
   begin : gPort
      rps_port_status uStatus (
         .clk(clk),
         .sys_rst(sys_rst),
         .fcStatusValid(fcStatusValid[p]),
         .fcVoltLevelA(fcVoltLevelA[p*3 +: 3]),
         .fcVoltLevelB(fcVoltLevelB[p*3 +: 3]),
         .fcTempLevel(fcTempLevel[p*3 +: 3]),
         .fcCsiFlags(fcCsiFlags[p*5 +: 5]),
         .bistStart(bistStart[p]),
         .bistErr(bistErr[p]),
         .remoteVoltageLevelA(voltA[p]),
         .remoteVoltageLevelB(voltB[p]),
         .remoteTempLevel(tempLvl[p]),
         .remoteCsiFlags(csiFlags[p]),
         .bistCount(bistCnt[p])
      );

      // Low-byte read of this port clears its whole counter
      assign parReadClear[p] = lowRead && portHot[p];

      rps_parity_counter #(
         .CNT_W(rps_pkg::PAR_CNT_W)
      ) uParity (
         .clk(clk),
         .sys_rst(sys_rst),
         .lockDetect(lockDetect[p]),
         .parityErr(parityErr[p]),
         .readClear(parReadClear[p]),
         .count(parCnt[p])
      );

      // Byte images of this port's registers
      assign imgVolt[p] = packVolt(voltB[p], voltA[p]);
      assign imgTemp[p] = packTemp(tempLvl[p]);
      assign imgCsi[p] = packCsi(csiFlags[p]);
      assign imgParHigh[p] = parCnt[p][rps_pkg::PAR_UPPER_LSB +: 8];
      assign imgParLow[p] = parCnt[p][7:0];
      assign imgBist[p] = bistCnt[p];
   end

   // Sensor images of the selected port; no port reads as zero
   always_comb
   begin
      selVolt = 8'h00;
      selTemp = 8'h00;
      selCsi = 8'h00;
      for (int i = 0; i < NUM_PORTS; i++)
      begin
         if (portHot[i])
         begin
            selVolt = imgVolt[i];
            selTemp = imgTemp[i];
            selCsi = imgCsi[i];
         end
      end
   end

   // Parity counter bytes of the selected port
   always_comb
   begin
      selParHigh = 8'h00;
      selParLow = 8'h00;
      for (int i = 0; i < NUM_PORTS; i++)
      begin
         if (portHot[i])
         begin
            selParHigh = imgParHigh[i];
            selParLow = imgParLow[i];
         end
      end
   end

   // Self-test count of the selected port
   always_comb
   begin
      selBist = 8'h00;
      for (int i = 0; i < NUM_PORTS; i++)
      begin
         if (portHot[i])
         begin
            selBist = imgBist[i];
         end
      end
   end

   // Combinational read mux ahead of the read data register; unmapped offsets read zero
   always_comb
   begin
      rdMux = 8'h00;
      case (regSel)
         rps_pkg::RPS_SEL_VOLT:
         begin
            rdMux = selVolt;
         end
         rps_pkg::RPS_SEL_TEMP:
         begin
            rdMux = selTemp;
         end
         rps_pkg::RPS_SEL_CSI:
         begin
            rdMux = selCsi;
         end
         rps_pkg::RPS_SEL_PARH:
         begin
            rdMux = selParHigh;
         end
         rps_pkg::RPS_SEL_PARL:
         begin
            rdMux = selParLow;
         end
         rps_pkg::RPS_SEL_BIST:
         begin
            rdMux = selBist;
         end
         default:
         begin
            rdMux = 8'h00;
         end
      endcase
   end

   // Next read data: held until the next read
   always_comb
   begin
      regRdData_nxt = regRdData_r;
      if (regRdEn)
      begin
         regRdData_nxt = rdMux;
      end
   end

   // Acknowledge any access to a mapped offset of a valid port; writes change nothing
   assign regHit_nxt = rdAccess | wrAccess;

   // Registered read data
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         regRdData_r <= rps_pkg::RD_DATA_RST;
      else
         regRdData_r <= regRdData_nxt;
   end

   // Read strobe, one cycle after the request
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         regRdValid_r <= 1'b0;
      else
         regRdValid_r <= regRdEn;
   end

   // Hit flag, one cycle after a mapped access
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         regHit_r <= 1'b0;
      else
         regHit_r <= regHit_nxt;
   end

   assign regRdData = regRdData_r;
   assign regRdValid = regRdValid_r;
   assign regHit = regHit_r;
endmodule

// ---- tb/rps_ser_model.sv ----
// Forward-channel status source standing in for remote serializers
`timescale 1ns/1ps
module rps_ser_model #(
   parameter int N = 3
)
(
   input wire logic clk,
   input wire logic [N-1:0] send,
   output logic [N-1:0] fcStatusValid = '0,
   output logic [N*3-1:0] fcVoltLevelA,
   output logic [N*3-1:0] fcVoltLevelB,
   output logic [N*3-1:0] fcTempLevel,
   output logic [N*5-1:0] fcCsiFlags
);
   // One status frame per send request
   always @(posedge clk)
   begin
      fcStatusValid <= send;
   end
   // Fields are inverted outside a frame so stale loads show up
   always_comb
   begin
      for (int p = 0; p < N; p++)
      begin
         fcVoltLevelA[3*p+:3] = 3'(p+1) ^ {3{!fcStatusValid[p]}};
         fcVoltLevelB[3*p+:3] = 3'(6-p) ^ {3{!fcStatusValid[p]}};
         fcTempLevel[3*p+:3] = 3'(p+3) ^ {3{!fcStatusValid[p]}};
         fcCsiFlags[5*p+:5] = 5'(5'h19 >> p) ^ {5{!fcStatusValid[p]}};
      end
   end
endmodule

// ---- tb/rps_regs_props.sv ----
// Checker for the remote status register port
`timescale 1ns/1ps
module rps_regs_props #(
   parameter int NUM_PORTS = 4,
   parameter int SEL_W = 2
)
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [SEL_W-1:0] portSelect,
   input wire logic [7:0] regAddr,
   input wire logic regRdEn,
   input wire logic regWrEn,
   input wire logic [NUM_PORTS-1:0] parityErr,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   input wire logic regHit
);
   logic mapped;
   logic req;
   // Decode of the group's offsets and port
   assign mapped = regAddr >= 8'h52 && regAddr <= 8'h57
      && portSelect < NUM_PORTS;
   assign req = regRdEn || regWrEn;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_read_answer: assert property (regRdEn |=> regRdValid)
      else $error("read not answered");
   a_hit_mapped: assert property (req && mapped |=> regHit)
      else $error("mapped access without hit");
   a_miss_unmapped: assert property (req && !mapped |=> !regHit)
      else $error("hit on unmapped access");
   a_miss_zero: assert property (regRdEn && !mapped |=> !regRdData)
      else $error("unmapped read not zero");
   a_volt_reserved: assert property (regRdEn && regAddr == 8'h52
      |=> !regRdData[7] && !regRdData[3])
      else $error("voltage reserved bits set");
   a_temp_reserved: assert property (regRdEn && regAddr == 8'h53
      |=> regRdData[7:3] == 5'h00)
      else $error("temperature reserved bits set");
   a_csi_reserved: assert property (regRdEn && regAddr == 8'h54
      |=> regRdData[7:5] == 3'h0)
      else $error("flag reserved bits set");
   a_data_holds: assert property (!regRdEn |=> $stable(regRdData))
      else $error("read data moved without read");
   a_low_clears: assert property ((regRdEn && regAddr == 8'h56
      && !parityErr[portSelect]) ##1 (regRdEn && regAddr == 8'h55
      && $stable(portSelect)) |=> regRdData == 8'h00)
      else $error("high byte not cleared");
endmodule
bind rps_remote_status_regs rps_regs_props #(.NUM_PORTS(NUM_PORTS),
   .SEL_W(SEL_W)) u_rps_regs_props (.clk(clk), .sys_rst(sys_rst),
   .portSelect(portSelect), .regAddr(regAddr), .regRdEn(regRdEn),
   .regWrEn(regWrEn), .parityErr(parityErr), .regRdData(regRdData),
   .regRdValid(regRdValid), .regHit(regHit));

// ---- tb/tb_top.sv ----
// Self-checking bench for the remote status register group
`timescale 1ns/1ps
module tb_top;
   typedef struct {logic [1:0] sel; logic [7:0] addr;
      logic [7:0] exp;} rps_row_t;
   logic clk = 0, sys_rst = 1, regRdEn = 0, regWrEn = 0;
   logic [1:0] portSelect = 0;
   logic [7:0] regAddr = 0, regRdData;
   logic [2:0] send = 0, lockDetect = 0, parityErr = 0, fv;
   logic [2:0] bistStart = 0, bistErr = 0;
   logic [8:0] fa, fb, ft;
   logic [14:0] ff;
   int n_errors = 0, n_compared = 0;
   rps_row_t rows [16];
   logic [7:0] al [4] = '{8'h52, 8'h53, 8'h54, 8'h58};
   // Clock of 20 ns
   always #10 clk = ~clk;
   rps_ser_model #(.N(3)) u_rps_ser_model (.clk(clk), .send(send),
      .fcStatusValid(fv), .fcVoltLevelA(fa), .fcVoltLevelB(fb),
      .fcTempLevel(ft), .fcCsiFlags(ff));
   rps_remote_status_regs #(.NUM_PORTS(3), .SEL_W(2))
      u_rps_remote_status_regs (.clk(clk), .sys_rst(sys_rst),
      .portSelect(portSelect), .regAddr(regAddr), .regRdEn(regRdEn),
      .regWrEn(regWrEn), .fcStatusValid(fv), .fcVoltLevelA(fa),
      .fcVoltLevelB(fb), .fcTempLevel(ft), .fcCsiFlags(ff),
      .lockDetect(lockDetect), .parityErr(parityErr),
      .bistStart(bistStart), .bistErr(bistErr), .regRdData(regRdData),
      .regRdValid(), .regHit());
   // Expected register byte for a port and offset
   function automatic logic [7:0] expv(int p, logic [7:0] a);
      if (p > 2) return 8'h00;
      case (a)
         8'h52: return {1'b0, 3'(6-p), 1'b0, 3'(p+1)};
         8'h53: return {5'h00, 3'(p+3)};
         8'h54: return {3'h0, 5'(5'h19 >> p)};
         default: return 8'h00;
      endcase
   endfunction
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task rd(input logic [1:0] s, input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      portSelect <= s;
      regAddr <= a;
      regRdEn <= 1;
      @(posedge clk);
      regRdEn <= 0;
      @(negedge clk);
      chk("read", regRdData, e);
   endtask
   task print_verdict;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #200000;
      n_errors++;
      print_verdict;
   end
   // Main sequence
   initial
   begin
      for (int i = 0; i < 16; i++)
         rows[i] = '{2'(i/4), al[i%4], expv(i/4, al[i%4])};
      repeat (2) @(posedge clk);
      sys_rst <= 0;
      rd(0, 8'h52, 8'h00);
      rd(1, 8'h56, 8'h00);
      @(posedge clk) send <= 3'h7;
      @(posedge clk) send <= 3'h0;
      foreach (rows[i])
         rd(rows[i].sel, rows[i].addr, rows[i].exp);
      @(posedge clk) regWrEn <= 1;
      regAddr <= 8'h52;
      @(posedge clk) regWrEn <= 0;
      rd(0, 8'h52, expv(0, 8'h52));
      @(posedge clk) lockDetect[1] <= 1;
      parityErr[1] <= 1;
      repeat (258) @(posedge clk);
      parityErr[1] <= 0;
      rd(1, 8'h55, 8'h01);
      rd(1, 8'h56, 8'h02);
      rd(1, 8'h55, 8'h00);
      rd(1, 8'h56, 8'h00);
      rd(0, 8'h56, 8'h00);
      @(posedge clk) parityErr[1] <= 1;
      repeat (3) @(posedge clk);
      parityErr[1] <= 0;
      lockDetect[1] <= 0;
      @(posedge clk) lockDetect[1] <= 1;
      rd(1, 8'h56, 8'h00);
      @(posedge clk) parityErr[1] <= 1;
      repeat (5) @(posedge clk);
      parityErr[1] <= 0;
      regAddr <= 8'h56;
      regRdEn <= 1;
      @(posedge clk) regAddr <= 8'h55;
      @(negedge clk) chk("low", regRdData, 8'h05);
      @(posedge clk) regRdEn <= 0;
      @(negedge clk) chk("high", regRdData, 8'h00);
      @(posedge clk) bistErr[2] <= 1;
      repeat (4) @(posedge clk);
      bistErr[2] <= 0;
      rd(2, 8'h57, 8'h04);
      @(posedge clk) bistStart[2] <= 1;
      @(posedge clk) bistStart[2] <= 0;
      rd(2, 8'h57, 8'h00);
      @(posedge clk) parityErr[1] <= 1;
      portSelect <= 1;
      regAddr <= 8'h56;
      regRdEn <= 1;
      @(posedge clk) parityErr[1] <= 0;
      regRdEn <= 0;
      @(negedge clk) chk("race", regRdData, 8'h00);
      rd(1, 8'h56, 8'h01);
      @(posedge clk) sys_rst <= 1;
      repeat (2) @(posedge clk);
      sys_rst <= 0;
      rd(1, 8'h52, 8'h00);
      print_verdict;
   end
endmodule
